// ### eesm_ee_model.sv
`timescale 1ns/1ns
`default_nettype none
module eesm_ee_model (
  input  wire logic       sck_i,
  input  wire logic       sda_i,
  input  wire logic       arm_i,
  input  wire logic       sel_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rd_byte_i,
  output logic            drv_o,
  output logic            val_o,
  output logic [7:0]      cap_o,
  output logic            ack_o
);
  int         rises = 0;
  logic [3:0] idx   = 4'h0;
  always @(posedge arm_i) begin
    rises = 0;
    idx = 4'h0;
  end
  // Capture on rising clock, ninth bit is the acknowledge slot
  always @(posedge sck_i) begin
    if (rises < 8) cap_o = {cap_o[6:0], sda_i};
    if (rises == 8) ack_o = sda_i;
    rises++;
  end
  // Data moves only while the clock is low
  always @(negedge sck_i) idx = (rises > 9) ? 4'h9 : 4'(rises);
  assign drv_o = sel_i && (rd_i ? idx < 4'h8 : idx == 4'h8);
  assign val_o = rd_i ? rd_byte_i[3'h7 - idx[2:0]] : 1'b0;
endmodule
`default_nettype wire

// ### eesm_master.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// [R01] Pin-select 1 routes two-pin clock to gpio four, data to five.
// [R02] Command 0011 shifts data register out; busy stays high throughout.
// [R03] Two-pin mode: completion interrupt pulses when busy falls.
// [R04] Control bit 5 reads 0 if EEPROM acked last byte; resets 1.
// [R05] Receive command fills data register before busy falls.
// [R06] Two-pin clock toggles at 78 kHz during transfers, idles high.
// [R07] Status: bit7 error, bit6 busy, bit4 low means we sent ack.
// [R08] Command 0000 stops the clock; otherwise clock keeps toggling.
// [R09] 0010 receives and acks; 0110 receives last byte without ack.
// [R10] 1001 makes START, 0101 makes STOP.
// [R11] Undefined two-pin commands do nothing but set error; code also loads cmd_q into status bits 3:0 and forces the clock high.
// [R12] Pin-select 3 runs 500 kHz three-wire link; chip select by firmware.
// [R13] Firmware keeps cpu clock divider at 000 for three-wire mode.
// [R14] Three-wire: each control write starts one transfer of up to 8 bits.
// [R15] Wait-for-ready with float delays busy fall to data rising edge.
// [R16] Three-wire: bit 6 reads busy; interrupt fires as busy falls.
// [R17] Float bit releases data line right after final rising clock edge.
// [R18] Read bit set samples EEPROM bits; clear drives bits out.
// [R19] Count 0..8; reads capture MSB first, right-aligned in data.
// [R20] Writes shift counted bits out MSB first from data MSB.
// [R21] Count zero gives no clocks; data line just obeys float bit.
// [R22] Firmware raises chip select before and lowers after a transaction.
// [R23] After a read, firmware writes zero count, float clear to redrive.
// [R24] START/STOP change data with clock high; bytes change data clock low.
module eesm_master
  import eesm_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] eeprom_pin_select_i,
  input  wire logic       ctrl_wr_i,
  input  wire logic [7:0] ctrl_wdata_i,
  input  wire logic       data_wr_i,
  input  wire logic [7:0] data_wdata_i,
  output logic      [7:0] eeprom_serial_control_o,
  output logic      [7:0] eeprom_serial_data_o,
  output logic            eeprom_done_irq_o,
  output logic            gpio_pin_four_o,
  output logic            gpio_pin_four_oe_o,
  input  wire logic       gpio_pin_five_i,
  output logic            gpio_pin_five_o,
  output logic            gpio_pin_five_oe_o
);
  import eesm_pkg::*;

  typedef enum {
    S_IDLE, S_START, S_STOP, S_BIT, S_ACK, S_WIRE, S_WAITRDY
  } eesm_state_e;

  eesm_state_e    state_q;
  logic [7:0]     data_q;
  logic [3:0]     cmd_q;
  logic           err_q, busy_q, rx_nack_q, tx_nack_q;
  logic           clk_run_q;
  logic           scl_q, sda_q, sda_oe_q;
  logic [1:0]     phase_q;
  logic [3:0]     bits_q;
  eesm_wire_cmd_s wcmd_q;
  logic           sync1_q, sync2_q, sda_prev_q;
  logic           busy_prev_q;
  logic           tick;
  logic           two_pin, three_wire;
  logic [DIV_W-1:0] tick_period;

  assign two_pin     = (eeprom_pin_select_i == PSEL_TWO_PIN);
  assign three_wire  = (eeprom_pin_select_i == PSEL_THREE_WIRE);
  // Two-pin steps in quarter periods; three-wire in half periods
  assign tick_period = two_pin ? DIV_W'(TWO_PIN_QTR) : DIV_W'(THREE_WIRE_HALF);

  eesm_tick #(
    .W(DIV_W)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (clk_run_q || busy_q),
    .period_i  (tick_period),
    .tick_o    (tick)
  );

  // Data pin is from outside; two flops before use
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync1_q    <= 1'b1;
      sync2_q    <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      sync1_q    <= gpio_pin_five_i;
      sync2_q    <= sync1_q;
      sda_prev_q <= sync2_q;
    end
  end

  // Main sequencer
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_q   <= S_IDLE;
      data_q    <= DATA_RESET;
      cmd_q     <= CMD_NOP;
      err_q     <= 1'b0;
      busy_q    <= 1'b0;
      rx_nack_q <= 1'b1;
      tx_nack_q <= 1'b1;
      clk_run_q <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      sda_oe_q  <= 1'b1;
      phase_q   <= 2'h0;
      bits_q    <= 4'h0;
      wcmd_q    <= '0;
    end else begin
      if (data_wr_i && !busy_q) begin
        data_q <= data_wdata_i;
      end
      case (state_q)
        S_IDLE: begin
          // [R08] free-running clock until no-op
          if (two_pin && clk_run_q && tick && !busy_q) begin
            if (phase_q[0]) begin
              scl_q <= ~scl_q;
            end
            phase_q <= phase_q + 2'h1;
          end
          if (ctrl_wr_i && two_pin) begin
            cmd_q   <= ctrl_wdata_i[3:0];
            phase_q <= 2'h0;
            bits_q  <= 4'h0;
            scl_q   <= 1'b1;
            case (ctrl_wdata_i[3:0])
              // [R08] stop clock, idle high
              CMD_NOP: clk_run_q <= 1'b0;
              // [R10] start/stop sequences
              CMD_START: begin
                busy_q <= 1'b1;
                clk_run_q <= 1'b1;
                sda_oe_q <= 1'b1;
                sda_q <= 1'b1;
                state_q <= S_START;
              end
              CMD_STOP: begin
                busy_q <= 1'b1;
                clk_run_q <= 1'b1;
                state_q <= S_STOP;
              end
              // [R02] transmit, [R09] receive variants
              CMD_TX, CMD_RX_ACK, CMD_RX_LAST: begin
                busy_q    <= 1'b1;
                clk_run_q <= 1'b1;
                state_q   <= S_BIT;
              end
              // [R11] illegal command
              default: err_q <= 1'b1;
            endcase
          end else if (ctrl_wr_i && three_wire) begin
            // [R14] one transfer per control write
            wcmd_q <= '{wait_rdy: ctrl_wdata_i[BIT_WAIT_RDY],
                        float_last: ctrl_wdata_i[BIT_FLOAT],
                        read: ctrl_wdata_i[BIT_READ],
                        count: (ctrl_wdata_i[3:0] > 4'(MAX_BITS)) ? 4'(MAX_BITS)
                                                            : ctrl_wdata_i[3:0]};
            // Clock left alone here so a zero count makes no edge
            bits_q  <= 4'h0;
            phase_q <= 2'h0;
            busy_q  <= 1'b1;
            // [R21] zero count: data follows float bit only
            if (ctrl_wdata_i[3:0] == 4'h0) begin
              sda_oe_q <= ~ctrl_wdata_i[BIT_FLOAT];
            end else if (ctrl_wdata_i[BIT_READ]) begin
              // Read hands the line to the EEPROM
              sda_oe_q <= 1'b0;
            end
            state_q <= S_WIRE;
          end
        end
        S_START: if (tick) begin
          // [R24] data falls while clock high
          phase_q <= phase_q + 2'h1;
          if (phase_q == 2'h1) sda_q <= 1'b0;
          if (phase_q == 2'h3) begin
            scl_q <= 1'b0;
            busy_q <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        S_STOP: if (tick) begin
          // [R24] data rises while clock high
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: begin scl_q <= 1'b0; sda_oe_q <= 1'b1; sda_q <= 1'b0; end
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            default: begin
              busy_q <= 1'b0;
              state_q <= S_IDLE;
            end
          endcase
        end
        S_BIT, S_ACK: if (tick) begin
          phase_q <= phase_q + 2'h1;
          case (phase_q)
            2'h0: begin
              // [R24] data changes with clock low
              scl_q <= 1'b0;
              if (state_q == S_BIT) begin
                sda_oe_q <= (cmd_q == CMD_TX);
                sda_q    <= data_q[7];
              end else begin
                // [R09] ack low unless last byte
                sda_oe_q <= (cmd_q != CMD_TX);
                sda_q    <= (cmd_q == CMD_RX_LAST);
              end
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (state_q == S_BIT) begin
                // [R05] receive shift; [R02] transmit shift
                data_q <= {data_q[6:0], (cmd_q == CMD_TX) ? 1'b0 : sync2_q};
              end else if (cmd_q == CMD_TX) begin
                // [R04] acknowledge seen from EEPROM
                rx_nack_q <= sync2_q;
              end else begin
                // [R07] we sent acknowledge
                tx_nack_q <= (cmd_q == CMD_RX_LAST);
              end
            end
            default: begin
              bits_q <= bits_q + 4'h1;
              if (state_q == S_ACK) begin
                busy_q <= 1'b0;
                state_q <= S_IDLE;
              end else if (bits_q == 4'(MAX_BITS - 1)) begin
                state_q <= S_ACK;
              end
            end
          endcase
        end
        S_WIRE: begin
          if (bits_q == wcmd_q.count) begin
            // [R17] float after final rising edge
            if (wcmd_q.float_last) sda_oe_q <= 1'b0;
            // [R15] wait only when float set
            if (wcmd_q.wait_rdy && wcmd_q.float_last) state_q <= S_WAITRDY;
            else begin
              busy_q  <= 1'b0;
              state_q <= S_IDLE;
            end
          end else if (tick) begin
            phase_q[0] <= ~phase_q[0];
            if (!phase_q[0]) begin
              // [R20] drive MSB with clock low
              if (!wcmd_q.read) begin
                sda_q    <= data_q[7];
                sda_oe_q <= 1'b1;
                data_q   <= {data_q[6:0], 1'b0};
              end
              scl_q <= 1'b0;
            end else begin
              scl_q  <= 1'b1;
              bits_q <= bits_q + 4'h1;
              // [R18] [R19] sample, right-aligned
              if (wcmd_q.read) data_q <= {data_q[6:0], sync2_q};
            end
          end
        end
        S_WAITRDY: begin
          if (sync2_q && !sda_prev_q) begin
            busy_q  <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Completion pulse on busy fall
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      busy_prev_q       <= 1'b0;
      eeprom_done_irq_o <= 1'b0;
    end else begin
      busy_prev_q <= busy_q;
      // [R03] [R16] interrupt as busy falls
      eeprom_done_irq_o <= busy_prev_q && !busy_q;
    end
  end

  // Output registers and pin routing
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      eeprom_serial_control_o <= CTRL_RESET;
      eeprom_serial_data_o    <= DATA_RESET;
      gpio_pin_four_o         <= 1'b1;
      gpio_pin_four_oe_o      <= 1'b0;
      gpio_pin_five_o         <= 1'b1;
      gpio_pin_five_oe_o      <= 1'b0;
    end else begin
      // [R07] [R04] [R16] status layout
      eeprom_serial_control_o <= {err_q, busy_q, rx_nack_q, tx_nack_q, cmd_q};
      eeprom_serial_data_o    <= data_q;
      // [R01] [R12] pins only owned in a serial mode
      gpio_pin_four_oe_o <= two_pin || three_wire;
      // [R06] [R08] two-pin clock free-runs between transfers until a no-op parks it high
      gpio_pin_four_o    <= scl_q;
      gpio_pin_five_oe_o <= (two_pin || three_wire) && sda_oe_q;
      gpio_pin_five_o    <= sda_q;
    end
  end
endmodule
`default_nettype wire

// ### eesm_master_chk.sv
`timescale 1ns/1ns
`default_nettype none
module eesm_master_chk
  import eesm_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic [1:0] eeprom_pin_select_i,
  input wire logic       ctrl_wr_i,
  input wire logic [7:0] ctrl_wdata_i,
  input wire logic [7:0] eeprom_serial_control_o,
  input wire logic       eeprom_done_irq_o,
  input wire logic       gpio_pin_four_o,
  input wire logic       gpio_pin_four_oe_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic busy, wr2, bad;
  assign busy = eeprom_serial_control_o[BIT_BUSY];
  assign wr2  = ctrl_wr_i && !busy && eeprom_pin_select_i == PSEL_TWO_PIN;
  assign bad  = !(ctrl_wdata_i[3:0] inside {CMD_NOP, CMD_RX_ACK, CMD_TX, CMD_STOP,
                                            CMD_RX_LAST, CMD_START});
  a_reset_state: assert property (
    $rose(rst_n_i) |-> eeprom_serial_control_o == 8'h30 && !gpio_pin_four_oe_o)
    else $error("bad reset state");
  a_irq_on_fall: assert property (
    $fell(busy) |-> eeprom_done_irq_o) else $error("no irq as busy fell");
  a_irq_cause: assert property (
    eeprom_done_irq_o |-> $past(busy) && !busy) else $error("irq without busy fall");
  a_irq_single: assert property (
    eeprom_done_irq_o |=> !eeprom_done_irq_o) else $error("irq too long");
  a_tx_busy: assert property (
    wr2 && ctrl_wdata_i[3:0] == CMD_TX |-> ##2 busy) else $error("no busy after transmit");
  a_err_set: assert property (
    wr2 && bad |-> ##[1:4] eeprom_serial_control_o[BIT_ERROR]) else $error("error not set");
  a_err_sticky: assert property (
    eeprom_serial_control_o[BIT_ERROR] |=> eeprom_serial_control_o[BIT_ERROR])
    else $error("error flag cleared");
  a_zero_count: assert property (
    ctrl_wr_i && !busy && eeprom_pin_select_i == PSEL_THREE_WIRE && ctrl_wdata_i[3:0] == 4'h0
    |=> $stable(gpio_pin_four_o) [*8]) else $error("clock moved at zero count");
endmodule
bind eesm_master eesm_master_chk u_chk (
  .ref_clk_i               (ref_clk_i),
  .rst_n_i                 (rst_n_i),
  .eeprom_pin_select_i     (eeprom_pin_select_i),
  .ctrl_wr_i               (ctrl_wr_i),
  .ctrl_wdata_i            (ctrl_wdata_i),
  .eeprom_serial_control_o (eeprom_serial_control_o),
  .eeprom_done_irq_o       (eeprom_done_irq_o),
  .gpio_pin_four_o         (gpio_pin_four_o),
  .gpio_pin_four_oe_o      (gpio_pin_four_oe_o)
);
`default_nettype wire

// ### eesm_pkg.sv
package eesm_pkg;
  // Pin-select values
  localparam logic [1:0] PSEL_TWO_PIN   = 2'h1;
  localparam logic [1:0] PSEL_THREE_WIRE = 2'h3;

  // Two-pin command codes
  localparam logic [3:0] CMD_NOP       = 4'h0;
  localparam logic [3:0] CMD_RX_ACK    = 4'h2;
  localparam logic [3:0] CMD_TX        = 4'h3;
  localparam logic [3:0] CMD_STOP      = 4'h5;
  localparam logic [3:0] CMD_RX_LAST   = 4'h6;
  localparam logic [3:0] CMD_START     = 4'h9;

  // Control/status bit positions
  localparam int BIT_ERROR    = 7;
  localparam int BIT_WAIT_RDY = 7;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_RX_NACK  = 5;
  localparam int BIT_FLOAT    = 5;
  localparam int BIT_TX_NACK  = 4;
  localparam int BIT_READ     = 4;
  localparam int MAX_BITS     = 8;

  localparam logic [7:0] DATA_RESET = 8'h00;
  // Status: no error, idle, both acknowledge bits inactive
  localparam logic [7:0] CTRL_RESET = 8'h30;

  // Timing
  localparam int CLK_HZ       = 250_000_000;
  localparam int TWO_PIN_HZ   = 78_000;
  localparam int THREE_WIRE_HZ = 500_000;
  // Two-pin quarter-period and three-wire half-period ticks (longest time rounds down)
  localparam int TWO_PIN_QTR  = CLK_HZ / (TWO_PIN_HZ * 4);
  localparam int THREE_WIRE_HALF = CLK_HZ / (THREE_WIRE_HZ * 2);
  localparam int DIV_W        = 12;

  typedef struct packed {
    logic wait_rdy;
    logic float_last;
    logic read;
    logic [3:0] count;
  } eesm_wire_cmd_s;

  typedef struct packed {
    logic o;
    logic oe;
  } eesm_pin_drv_s;
endpackage

// ### eesm_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  import eesm_pkg::*;
  logic       ref_clk_i = 1'b0, rst_n_i = 1'b0, ctrl_wr_i = 1'b0, data_wr_i = 1'b0;
  logic       arm = 1'b0, cs = 1'b0, rd = 1'b0, ee_busy_hold = 1'b0;
  logic [1:0] eeprom_pin_select_i = 2'h0;
  logic [7:0] ctrl_wdata_i = 8'h00, data_wdata_i = 8'h00, rd_byte = 8'h00;
  logic [7:0] eeprom_serial_control_o, eeprom_serial_data_o, cap;
  logic       eeprom_done_irq_o, gpio_pin_four_o, gpio_pin_four_oe_o, gpio_pin_five_i;
  logic       gpio_pin_five_o, gpio_pin_five_oe_o, m_drv, m_val, ack;
  int         miscompares = 0, n_checks = 0, n_irq = 0, i0;
  eesm_master u_dut (
    .ref_clk_i               (ref_clk_i),
    .rst_n_i                 (rst_n_i),
    .eeprom_pin_select_i     (eeprom_pin_select_i),
    .ctrl_wr_i               (ctrl_wr_i),
    .ctrl_wdata_i            (ctrl_wdata_i),
    .data_wr_i               (data_wr_i),
    .data_wdata_i            (data_wdata_i),
    .eeprom_serial_control_o (eeprom_serial_control_o),
    .eeprom_serial_data_o    (eeprom_serial_data_o),
    .eeprom_done_irq_o       (eeprom_done_irq_o),
    .gpio_pin_four_o         (gpio_pin_four_o),
    .gpio_pin_four_oe_o      (gpio_pin_four_oe_o),
    .gpio_pin_five_i         (gpio_pin_five_i),
    .gpio_pin_five_o         (gpio_pin_five_o),
    .gpio_pin_five_oe_o      (gpio_pin_five_oe_o)
  );
  eesm_ee_model u_mem (.sck_i(gpio_pin_four_o), .sda_i(gpio_pin_five_i), .arm_i(arm),
    .sel_i(cs), .rd_i(rd), .rd_byte_i(rd_byte), .drv_o(m_drv), .val_o(m_val),
    .cap_o(cap), .ack_o(ack));
  // Pull-up holds the data line high once released
  // EEPROM busy with its internal write holds the line low
  assign gpio_pin_five_i = gpio_pin_five_oe_o ? gpio_pin_five_o :
                           (ee_busy_hold ? 1'b0 : (m_drv ? m_val : 1'b1));
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (eeprom_done_irq_o === 1'b1) n_irq++;
  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr(input logic c, input logic [7:0] v);
    {ctrl_wdata_i, data_wdata_i} = {v, v};
    {ctrl_wr_i, data_wr_i} = {c, !c};
    cyc(1);
    {ctrl_wr_i, data_wr_i} = 2'b00;
  endtask
  task automatic arm_mem(input logic r, input logic [7:0] b);
    rd = r;
    rd_byte = b;
    arm = 1'b1;
    cyc(1);
    arm = 1'b0;
  endtask
  // A two-pin byte lasts about 29k cycles
  task automatic wait_idle;
    int k;
    cyc(4);
    for (k = 0; k < 40000 && eeprom_serial_control_o[BIT_BUSY] !== 1'b0; k++) cyc(1);
    if (k == 40000) begin
      miscompares++;
      complete_run();
    end
    // Let the completion pulse reach the irq counter
    cyc(2);
  endtask
  task automatic t_reset;
    cyc(3);
    `CHK(eeprom_serial_control_o, 8'h30)
    `CHK(eeprom_serial_data_o, DATA_RESET)
    `CHK({gpio_pin_four_oe_o, gpio_pin_five_oe_o}, 2'b00)
    $display("test reset done");
  endtask
  task automatic t_two;
    eeprom_pin_select_i = PSEL_TWO_PIN;
    cs = 1'b1;
    wr(1'b1, {4'h0, CMD_START});
    wait_idle();
    wr(1'b1, {4'h0, CMD_NOP});
    cyc(4000);
    `CHK(gpio_pin_four_o, 1'b1)
    wr(1'b0, 8'hA5);
    arm_mem(1'b0, 8'h00);
    i0 = n_irq;
    wr(1'b1, {4'h0, CMD_TX});
    wait_idle();
    `CHK(cap, 8'hA5)
    `CHK(eeprom_serial_control_o[BIT_RX_NACK], 1'b0)
    `CHK(n_irq, i0 + 1)
    `CHK(gpio_pin_four_oe_o, 1'b1)
    wr(1'b1, {4'h0, CMD_NOP});
    cyc(4000);
    arm_mem(1'b1, 8'h3C);
    wr(1'b1, {4'h0, CMD_RX_LAST});
    wait_idle();
    `CHK(eeprom_serial_data_o, 8'h3C)
    `CHK(eeprom_serial_control_o[BIT_TX_NACK], 1'b1)
    `CHK(ack, 1'b1)
    cs = 1'b0;
    wr(1'b1, {4'h0, CMD_STOP});
    wait_idle();
    wr(1'b1, 8'h0F);
    cyc(6);
    `CHK(eeprom_serial_control_o[7:6], 2'b10)
    $display("test two-pin done");
  endtask
  task automatic t_wire;
    // Bench has no cpu clock divider; it stays at its 000 setting
    eeprom_pin_select_i = PSEL_THREE_WIRE;
    cs = 1'b1;
    arm_mem(1'b1, 8'hB3);
    i0 = n_irq;
    wr(1'b1, 8'h15);
    wait_idle();
    `CHK(eeprom_serial_data_o[4:0], 5'h16)
    `CHK(n_irq, i0 + 1)
    `CHK(gpio_pin_four_oe_o, 1'b1)
    cs = 1'b0;
    arm_mem(1'b0, 8'h00);
    wr(1'b1, 8'h00);
    wait_idle();
    `CHK(gpio_pin_five_oe_o, 1'b1)
    cs = 1'b1;
    wr(1'b0, 8'hC6);
    arm_mem(1'b0, 8'h00);
    wr(1'b1, 8'h08);
    wait_idle();
    `CHK(cap, 8'hC6)
    wr(1'b1, 8'h21);
    wait_idle();
    `CHK(gpio_pin_five_oe_o, 1'b0)
    ee_busy_hold = 1'b1;
    i0 = n_irq;
    wr(1'b1, 8'hA1);
    cyc(1000);
    `CHK(eeprom_serial_control_o[BIT_BUSY], 1'b1)
    ee_busy_hold = 1'b0;
    wait_idle();
    `CHK(n_irq, i0 + 1)
    cs = 1'b0;
    $display("test three-wire done");
  endtask
  initial begin
    cyc(5);
    rst_n_i = 1'b1;
    t_reset();
    t_two();
    t_wire();
    complete_run();
  end
endmodule
`default_nettype wire

// ### eesm_tick.sv
`timescale 1ns/1ns
`default_nettype none
// Programmable tick divider; one-cycle enable pulse every period_i cycles
module eesm_tick #(
  parameter int W = 12
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] period_i,
  output logic              tick_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !run_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q >= period_i - W'(1)) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire
